// [core/hmi_pkg.sv]
// Package: constants and carriers for the interrupt status flag block
package hmi_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  STS_OFFSET        = 8'h58;
  localparam logic [7:0]  EN_OFFSET         = 8'h5c;
  localparam logic [7:0]  LVL_OFFSET        = 8'h68;
  localparam logic [15:0] STS_RESET         = 16'h0000;
  localparam logic [15:0] EN_RESET          = 16'h0000;
  localparam logic [31:0] LVL_RESET         = 32'h48000000;
  // Bits that carry a flag; 11, 5 and 2..0 are reserved
  localparam logic [15:0] STS_IMPL_MASK     = 16'hf7d8;
  // Sticky write-one-to-clear flags (bit 12 is a live mirror)
  localparam logic [15:0] STS_W1C_MASK      = 16'he7d8;
  localparam logic [15:0] EN_WRITE_MASK     = 16'hffff;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_OVERSIZE   = 15;
  localparam int BIT_RX_ERR     = 14;
  localparam int BIT_TX_ERR     = 13;
  localparam int BIT_PIN_EVENT  = 12;
  localparam int BIT_TX_OVERRUN = 10;
  localparam int BIT_TX_SPACE   = 9;
  localparam int BIT_TXQ_FULL   = 8;
  localparam int BIT_TXQ_LEVEL  = 7;
  localparam int BIT_RX_DROP    = 6;
  localparam int BIT_RXQ_FULL   = 4;
  localparam int BIT_RXQ_LEVEL  = 3;
  localparam int LVL_TXSPACE_LSB = 24;
  localparam int LVL_TXQ_LSB     = 16;
  localparam int LVL_RXQ_LSB     = 0;

  // ---------------------------------------------------------------
  // Frame length limits in bytes
  // ---------------------------------------------------------------
  localparam logic [15:0] RX_MAX_LEN        = 16'h0800;
  localparam logic [15:0] TAG_BYTES         = 16'h0004;
  localparam logic [15:0] UNTAGGED_MAX_LEN  = 16'h07fc;
  localparam int          SPACE_BLOCK_SHIFT = 6;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        frameDone;
    logic [15:0] frameLen;
    logic        tagInserted;
    logic        rxError;
    logic        frameDropped;
  } hmi_rx_ev_t;

  typedef struct packed {
    logic        txError;
    logic        dataWrite;
    logic        dataFull;
    logic [15:0] dataFreeBytes;
    logic [7:0]  txqUsed;
    logic        txqFull;
    logic [7:0]  rxqUsed;
    logic        rxqFull;
  } hmi_fifo_ev_t;

  typedef struct packed {
    logic [15:0] sts;
    logic [15:0] en;
    logic [7:0]  txSpaceLvl;
    logic [7:0]  txqLvl;
    logic [7:0]  rxqLvl;
    logic [31:0] rdata;
    logic        irq;
  } hmi_state_t;

endpackage : hmi_pkg

// [core/hmi_irq_status.sv]
// Lower interrupt status flags with enables, levels and host register access
//
// Notes on behaviour
// - Set oversize flag, bit 15, on received frame longer than 2048 bytes.
// - Also set it when tagging an untagged frame above 2044 bytes.
// - Set receive error flag, bit 14, on any receive error.
// - Set transmit error flag, bit 13, on any transmit error.
// - Bit 12 is read-only mirror of pin event status block.
// - Set bit 10 when host writes TX data FIFO while full.
// - Set bit 9 when TX free space exceeds programmed level.
// - Set bit 8 whenever TX result queue becomes full.
// - Set bit 7 when TX result queue reaches programmed level.
// - Set bit 6 each time a received frame is dropped.
// - Set bit 4 whenever RX result queue becomes full.
// - Set bit 3 when RX result queue reaches programmed level.
// - Writing one clears a sticky flag; writing zero leaves it.
// - Only enabled flags drive interrupt; flags record regardless of enable.
// - TX space level counts 64-byte blocks of free space.
`timescale 1ns/1ps

module hmi_irq_status
  import hmi_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         regWrite,
  input  wire logic         regRead,
  input  wire logic [7:0]   regAddr,
  input  wire logic [31:0]  regWdata,
  output logic      [31:0]  regRdata,
  input  wire hmi_rx_ev_t   rxEv,
  input  wire hmi_fifo_ev_t fifoEv,
  input  wire logic         pinEventPending,
  output logic              irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  hmi_state_t  s_q;
  hmi_state_t  s_d;

  // ---------------------------------------------------------------
  // Combinational helpers
  // ---------------------------------------------------------------
  logic [15:0] events;
  logic [15:0] clearMask;
  logic [15:0] stsView;
  logic [7:0]  freeBlocks;
  logic        txqAtLvl;
  logic        rxqAtLvl;
  logic        stsWrite;
  logic        enWrite;
  logic        lvlWrite;
  logic        lenAboveTag;
  logic        oversizeLen;
  logic        oversizeTag;
  logic        txqFullRise;
  logic        rxqFullRise;
  logic        txqLvlRise;
  logic        rxqLvlRise;

  // ---------------------------------------------------------------
  // Edge detectors
  // ---------------------------------------------------------------
  // TX result queue becomes full
  hmi_rise_detect i_txqFull (
    .clk   (clk),
    .nrst  (nrst),
    .level (fifoEv.txqFull),
    .rise  (txqFullRise)
  );

  hmi_rise_detect i_txqLvl (
    .clk   (clk),
    .nrst  (nrst),
    .level (txqAtLvl),
    .rise  (txqLvlRise)
  );

  hmi_rise_detect i_rxqFull (
    .clk   (clk),
    .nrst  (nrst),
    .level (fifoEv.rxqFull),
    .rise  (rxqFullRise)
  );

  hmi_rise_detect i_rxqLvl (
    .clk   (clk),
    .nrst  (nrst),
    .level (rxqAtLvl),
    .rise  (rxqLvlRise)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    events      = 16'h0000;
    clearMask   = 16'h0000;
    stsView     = 16'h0000;
    stsWrite    = regWrite && (regAddr == STS_OFFSET);
    enWrite     = regWrite && (regAddr == EN_OFFSET);
    lvlWrite    = regWrite && (regAddr == LVL_OFFSET);

    freeBlocks  = 8'(fifoEv.dataFreeBytes >> SPACE_BLOCK_SHIFT);
    txqAtLvl    = (fifoEv.txqUsed >= s_q.txqLvl);
    rxqAtLvl    = (fifoEv.rxqUsed >= s_q.rxqLvl);

    // Guard the subtraction; a runt would wrap to a huge length
    lenAboveTag = (rxEv.frameLen >= TAG_BYTES);
    oversizeLen = rxEv.frameDone && (rxEv.frameLen > RX_MAX_LEN);
    // inserted tag pushes frame over limit
    oversizeTag = rxEv.frameDone && rxEv.tagInserted && lenAboveTag
                  && ((rxEv.frameLen - TAG_BYTES) > UNTAGGED_MAX_LEN);

    events[BIT_OVERSIZE]   = oversizeLen || oversizeTag;
    events[BIT_RX_ERR]     = rxEv.rxError;
    events[BIT_TX_ERR]     = fifoEv.txError;
    events[BIT_TX_OVERRUN] = fifoEv.dataWrite && fifoEv.dataFull;
    // level-sensitive, sets again after a clear while space lasts
    events[BIT_TX_SPACE]   = (freeBlocks > s_q.txSpaceLvl);
    events[BIT_TXQ_FULL]   = txqFullRise;
    events[BIT_TXQ_LEVEL]  = txqLvlRise;
    events[BIT_RX_DROP]    = rxEv.frameDropped;
    events[BIT_RXQ_FULL]   = rxqFullRise;
    events[BIT_RXQ_LEVEL]  = rxqLvlRise;

    if (stsWrite) begin
      clearMask = regWdata[15:0] & STS_W1C_MASK;
    end
    s_d.sts = ((s_q.sts & ~clearMask) | events) & STS_W1C_MASK;
    // live mirror, lags the pin by one cycle
    s_d.sts[BIT_PIN_EVENT] = pinEventPending;

    // Enable bits stored whole; reserved ones never gate the request
    if (enWrite) begin
      s_d.en = regWdata[15:0] & EN_WRITE_MASK;
    end
    if (lvlWrite) begin
      s_d.txSpaceLvl = regWdata[LVL_TXSPACE_LSB +: 8];
      s_d.txqLvl     = regWdata[LVL_TXQ_LSB +: 8];
      s_d.rxqLvl     = regWdata[LVL_RXQ_LSB +: 8];
    end

    stsView   = s_q.sts & STS_IMPL_MASK;
    // Read data is zero outside the answer cycle
    s_d.rdata = 32'h00000000;
    if (regRead) begin
      case (regAddr)
        STS_OFFSET: begin
          s_d.rdata = {16'h0000, stsView};
        end
        EN_OFFSET: begin
          s_d.rdata = {16'h0000, s_q.en};
        end
        LVL_OFFSET: begin
          s_d.rdata = {s_q.txSpaceLvl, s_q.txqLvl, 8'h00, s_q.rxqLvl};
        end
        default: begin
          s_d.rdata = 32'h00000000;
        end
      endcase
    end

    // only enabled flags reach the request
    s_d.irq = |(s_d.sts & s_d.en & STS_IMPL_MASK);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q.sts        <= STS_RESET;
      s_q.en         <= EN_RESET;
      s_q.txSpaceLvl <= LVL_RESET[LVL_TXSPACE_LSB +: 8];
      s_q.txqLvl     <= LVL_RESET[LVL_TXQ_LSB +: 8];
      s_q.rxqLvl     <= LVL_RESET[LVL_RXQ_LSB +: 8];
      s_q.rdata      <= 32'h00000000;
      s_q.irq        <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign regRdata = s_q.rdata;
  assign irq      = s_q.irq;

endmodule : hmi_irq_status

// ---------------------------------------------------------------
// Rising edge of a level
// ---------------------------------------------------------------
module hmi_rise_detect
  import hmi_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic level,
  output logic      rise
);

  logic seen_q;
  logic seen_d;

  always_comb begin
    seen_d = level;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= seen_d;
    end
  end

  // Reset low, so a level already true after reset counts as an edge
  assign rise = level && !seen_q;

endmodule : hmi_rise_detect

// [sim/hmi_irq_status_asserts.sv]
// Checker for the interrupt status flag block
`timescale 1ns/1ps
module hmi_irq_status_asserts
  import hmi_pkg::*;
(
  input wire logic         clk,
  input wire logic         nrst,
  input wire logic         regWrite,
  input wire logic         regRead,
  input wire logic [7:0]   regAddr,
  input wire logic [31:0]  regWdata,
  input wire logic [31:0]  regRdata,
  input wire hmi_rx_ev_t   rxEv,
  input wire hmi_fifo_ev_t fifoEv,
  input wire logic         pinEventPending,
  input wire logic         irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rdSts;
  assign rdSts = regRead && regAddr == STS_OFFSET;
  a_read_idle: assert property (!regRead |=> regRdata == 32'h0)
    else $error("read data not zero when idle");
  a_rsvd_zero: assert property (rdSts |=> (regRdata & ~{16'h0, STS_IMPL_MASK}) == 32'h0)
    else $error("reserved status bits not zero");
  a_unmapped_zero: assert property (regRead && regAddr == 8'h60 |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  a_drop_seen: assert property (rxEv.frameDropped ##1 rdSts |=> regRdata[6])
    else $error("dropped frame flag missing");
  a_oversize_seen: assert property (rxEv.frameDone && rxEv.frameLen > RX_MAX_LEN ##1 rdSts |=> regRdata[15])
    else $error("oversize flag missing");
  a_rx_error: assert property (rxEv.rxError ##1 rdSts |=> regRdata[14])
    else $error("receive error flag missing");
  a_tx_error: assert property (fifoEv.txError ##1 rdSts |=> regRdata[13])
    else $error("transmit error flag missing");
  a_overrun_seen: assert property (fifoEv.dataWrite && fifoEv.dataFull ##1 rdSts |=> regRdata[10])
    else $error("overrun flag missing");
  a_pin_mirror: assert property (pinEventPending ##1 rdSts |=> regRdata[12])
    else $error("pin event mirror missing");
  c_irq: cover property (irq);
  c_drop_read: cover property (rdSts ##1 regRdata[6]);
  c_sts_write: cover property (regWrite && regAddr == STS_OFFSET);
endmodule : hmi_irq_status_asserts

bind hmi_irq_status hmi_irq_status_asserts i_chk (.clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata,
  .regRdata, .rxEv, .fifoEv, .pinEventPending, .irq);

// [sim/hmi_irq_status_bench.sv]
// Self-checking bench for the interrupt status flag block
`timescale 1ns/1ps
module hmi_irq_status_bench
  import hmi_pkg::*;
;
  logic         clk = 0, nrst = 0, regWrite = 0, regRead = 0, pinEventPending = 0, irq;
  logic [7:0]   regAddr = 8'h0;
  logic [31:0]  regWdata = 32'h0, regRdata;
  hmi_rx_ev_t   rxEv = '0;
  hmi_fifo_ev_t fifoEv = '0;
  int           miscompares = 0, checks = 0;
  int           bits[6] = '{6, 14, 13, 10, 15, 12};

  hmi_irq_status i_dut (.clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .rxEv, .fifoEv,
    .pinEventPending, .irq);

  initial forever #25 clk = ~clk;
  task step; @(posedge clk); #1; endtask : step
  task chk(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [31:0] d);
    regAddr = a; regWdata = d; regWrite = 1; step; regWrite = 0; step;
  endtask : wr
  task rd(logic [7:0] a, logic [31:0] e);
    regAddr = a; regRead = 1; step; regRead = 0; chk(regRdata, e); step;
  endtask : rd
  task results;
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // Whole run is under a hundred cycles
  initial begin
    #50000;
    miscompares++;
    results;
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 nrst = 1;
    step;
    rd(LVL_OFFSET, LVL_RESET);
    rd(EN_OFFSET, 32'h0);
    // Levels of zero are reached straight after reset
    rd(STS_OFFSET, 32'h0088);
    wr(STS_OFFSET, 32'hffff);
    rd(STS_OFFSET, 32'h0);
    for (int k = 0; k < 6; k++) begin
      case (k)
        0: rxEv.frameDropped = 1;
        1: rxEv.rxError = 1;
        2: fifoEv.txError = 1;
        3: fifoEv = '{dataWrite: 1, dataFull: 1, default: '0};
        4: rxEv = '{frameDone: 1, frameLen: 16'h0801, tagInserted: 1, default: '0};
        default: pinEventPending = 1;
      endcase
      step;
      rxEv = '0; fifoEv = '0; pinEventPending = 0;
      rd(STS_OFFSET, 32'h1 << bits[k]);
      wr(STS_OFFSET, 32'h1 << bits[k]);
    end
    rd(STS_OFFSET, 32'h0);
    // Event and clear in one cycle: the event must win
    rxEv.frameDropped = 1; regAddr = STS_OFFSET; regWdata = 32'h40; regWrite = 1; step;
    rxEv = '0; regWrite = 0; step;
    rd(STS_OFFSET, 32'h40);
    wr(STS_OFFSET, 32'h0);
    rd(STS_OFFSET, 32'h40);
    wr(EN_OFFSET, 32'h40);
    chk(32'(irq), 32'h1);
    wr(STS_OFFSET, 32'h40);
    chk(32'(irq), 32'h0);
    rd(EN_OFFSET, 32'h40);
    wr(LVL_OFFSET, 32'h01030002);
    fifoEv = '{dataFreeBytes: 16'h0040, txqUsed: 8'h03, rxqUsed: 8'h02, txqFull: 1, rxqFull: 1, default: '0};
    step;
    rd(STS_OFFSET, 32'h0198);
    fifoEv.dataFreeBytes = 16'h0080;
    step;
    rd(STS_OFFSET, 32'h0398);
    wr(8'h60, 32'hffffffff);
    rd(8'h60, 32'h0);
    results;
  end
endmodule : hmi_irq_status_bench
